// ===== hdl/phy_status_summary_pkg.sv
// Purpose: constants for the low status summary register
// Assumes: management register index space of 5 bits
// Notes: bits 15:9 read as zero here
package phy_status_summary_pkg;
  localparam logic [4:0] ADDR_BASIC_STATUS = 5'h01;
  localparam logic [4:0] ADDR_AUTONEG_EXPANSION = 5'h06;
  localparam logic [4:0] ADDR_STATUS_SUMMARY = 5'h10;
  localparam logic [4:0] ADDR_INTERRUPT_STATUS = 5'h12;
  localparam int BIT_LINK = 0;
  localparam int BIT_SPEED10 = 1;
  localparam int BIT_DUPLEX = 2;
  localparam int BIT_LOOPBACK = 3;
  localparam int BIT_AN_DONE = 4;
  localparam int BIT_JABBER = 5;
  localparam int BIT_REMOTE_FAULT = 6;
  localparam int BIT_INT_PENDING = 7;
  localparam int BIT_PAGE_RX = 8;
  localparam int STATUS_BITS = 9;
  localparam logic [15:0] SUMMARY_RESET = 16'h0000;
endpackage

// ===== hdl/phy_status_summary_low.sv
// Purpose: low nine bits of the status summary register
// Assumes: one management read per rd_strobe pulse, inputs synchronous
// Notes: sticky flags clear only on reset or on reads of their source registers
//
// How it works
// - bit 8 shows page received, sticky until read
// - page received sets on page, clears reading 06h
// - bit 7 pending interrupt, cleared reading 12h
// - remote fault sets on notice, clears reading 01h
// - bit 5 mirrors jabber flag at any speed
// - bit 4 shows auto-negotiation complete
// - bit 3 shows loopback enabled
// - bit 2 shows duplex, one is full
// - bit 1 shows speed, one is 10 Mb/s
// - bit 0 mirrors link flag, unchanged by read
`timescale 1ns/1ps
module phy_status_summary_low
  import phy_status_summary_pkg::*;
(
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic rd_strobe,
  input wire logic wr_strobe,
  input wire logic [4:0] reg_addr,
  input wire logic page_rx_event,
  input wire logic interrupt_event,
  input wire logic remote_fault_event,
  input wire logic jabber_flag,
  input wire logic autoneg_done,
  input wire logic loopback_en,
  input wire logic full_duplex,
  input wire logic speed_10,
  input wire logic link_flag,
  output logic [15:0] rd_data,
  output logic [STATUS_BITS-1:0] status_bits
);

  // ***********************************************
  // clear decode
  // ***********************************************
  function automatic logic read_of(input logic rd, input logic [4:0] a, input logic [4:0] target);
    read_of = rd && (a == target);
  endfunction

  wire clr_page = read_of(rd_strobe, reg_addr, ADDR_AUTONEG_EXPANSION);
  wire clr_int = read_of(rd_strobe, reg_addr, ADDR_INTERRUPT_STATUS);
  wire clr_fault = read_of(rd_strobe, reg_addr, ADDR_BASIC_STATUS);
  wire sel_summary = read_of(rd_strobe, reg_addr, ADDR_STATUS_SUMMARY);

  logic page_rx;
  logic int_pending;
  logic remote_fault;

  // set wins over clear
  wire next_page_rx = page_rx_event | (page_rx & ~clr_page);
  wire next_int_pending = interrupt_event | (int_pending & ~clr_int);
  wire next_remote_fault = remote_fault_event | (remote_fault & ~clr_fault);

  logic [STATUS_BITS-1:0] next_status;
  always_comb begin
    next_status = '0;
    next_status[BIT_PAGE_RX] = next_page_rx;
    next_status[BIT_INT_PENDING] = next_int_pending;
    next_status[BIT_REMOTE_FAULT] = next_remote_fault;
    next_status[BIT_JABBER] = jabber_flag;
    next_status[BIT_AN_DONE] = autoneg_done;
    next_status[BIT_LOOPBACK] = loopback_en;
    next_status[BIT_DUPLEX] = full_duplex;
    next_status[BIT_SPEED10] = speed_10;
    next_status[BIT_LINK] = link_flag;
  end

  // ***********************************************
  // state and read port
  // ***********************************************
  // summary word, bits above the status field zero
  wire [15:0] next_rd_data = sel_summary ? {7'h00, status_bits} : SUMMARY_RESET;

  // wr_strobe watched by assertions only: register is read only
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      page_rx <= 1'b0;
      int_pending <= 1'b0;
      remote_fault <= 1'b0;
      status_bits <= '0;
      rd_data <= SUMMARY_RESET;
    end else begin
      page_rx <= next_page_rx;
      int_pending <= next_int_pending;
      remote_fault <= next_remote_fault;
      status_bits <= next_status;
      rd_data <= next_rd_data;
    end
  end

  // ***********************************************
  // assertions: sticky flags
  // ***********************************************
  // clearing reads with no event in the same cycle
  sequence s_page_read;
    clr_page && !page_rx_event;
  endsequence

  sequence s_int_read;
    clr_int && !interrupt_event;
  endsequence

  sequence s_fault_read;
    clr_fault && !remote_fault_event;
  endsequence

  // flag and its summary bit move together
  sequence s_page_up;
    page_rx && status_bits[BIT_PAGE_RX];
  endsequence

  sequence s_int_up;
    int_pending && status_bits[BIT_INT_PENDING];
  endsequence

  sequence s_fault_up;
    remote_fault && status_bits[BIT_REMOTE_FAULT];
  endsequence

  property p_page_hold;
    @(posedge clk_sys) disable iff (!arst_n)
      page_rx && !clr_page |=> page_rx;
  endproperty
  a_page_hold: assert property (p_page_hold) else $error("page flag lost");

  property p_page_set;
    @(posedge clk_sys) disable iff (!arst_n)
      page_rx_event |=> s_page_up;
  endproperty
  a_page_set: assert property (p_page_set) else $error("page flag not set");

  property p_page_clear;
    @(posedge clk_sys) disable iff (!arst_n)
      s_page_read |=> !page_rx && !status_bits[BIT_PAGE_RX];
  endproperty
  a_page_clear: assert property (p_page_clear) else $error("page flag not cleared");

  property p_int;
    @(posedge clk_sys) disable iff (!arst_n)
      interrupt_event |=> s_int_up;
  endproperty
  a_int: assert property (p_int) else $error("interrupt not shown");

  property p_int_clear;
    @(posedge clk_sys) disable iff (!arst_n)
      s_int_read |=> !int_pending && !status_bits[BIT_INT_PENDING];
  endproperty
  a_int_clear: assert property (p_int_clear) else $error("interrupt not cleared");

  property p_fault_set;
    @(posedge clk_sys) disable iff (!arst_n)
      remote_fault_event |=> s_fault_up;
  endproperty
  a_fault_set: assert property (p_fault_set) else $error("fault not shown");

  property p_fault;
    @(posedge clk_sys) disable iff (!arst_n)
      s_fault_read |=> !remote_fault && !status_bits[BIT_REMOTE_FAULT];
  endproperty
  a_fault: assert property (p_fault) else $error("fault not cleared");

  // ***********************************************
  // assertions: mirrored levels
  // ***********************************************
  property p_jabber;
    @(posedge clk_sys) disable iff (!arst_n)
      1 |=> status_bits[BIT_JABBER] == $past(jabber_flag);
  endproperty
  a_jabber: assert property (p_jabber) else $error("jabber mismatch");

  property p_an;
    @(posedge clk_sys) disable iff (!arst_n)
      1 |=> status_bits[BIT_AN_DONE] == $past(autoneg_done);
  endproperty
  a_an: assert property (p_an) else $error("autoneg mismatch");

  property p_loop;
    @(posedge clk_sys) disable iff (!arst_n)
      1 |=> status_bits[BIT_LOOPBACK] == $past(loopback_en);
  endproperty
  a_loop: assert property (p_loop) else $error("loopback mismatch");

  property p_dup_spd;
    @(posedge clk_sys) disable iff (!arst_n)
      1 |=> status_bits[BIT_DUPLEX] == $past(full_duplex) && status_bits[BIT_SPEED10] == $past(speed_10);
  endproperty
  a_dup_spd: assert property (p_dup_spd) else $error("duplex or speed mismatch");

  property p_link;
    @(posedge clk_sys) disable iff (!arst_n)
      1 |=> status_bits[BIT_LINK] == $past(link_flag);
  endproperty
  a_link: assert property (p_link) else $error("link mismatch");

  // ***********************************************
  // assertions: read port
  // ***********************************************
  sequence s_lone_write;
    wr_strobe && !rd_strobe && !page_rx_event && !interrupt_event && !remote_fault_event;
  endsequence

  property p_read;
    @(posedge clk_sys) disable iff (!arst_n)
      sel_summary |=> rd_data == {7'h00, $past(status_bits)}
        && page_rx == ($past(page_rx) || $past(page_rx_event))
        && int_pending == ($past(int_pending) || $past(interrupt_event))
        && remote_fault == ($past(remote_fault) || $past(remote_fault_event));
  endproperty
  a_read: assert property (p_read) else $error("summary read wrong");

  property p_idle;
    @(posedge clk_sys) disable iff (!arst_n)
      !sel_summary |=> rd_data == SUMMARY_RESET;
  endproperty
  a_idle: assert property (p_idle) else $error("read data not idle");

  property p_write;
    @(posedge clk_sys) disable iff (!arst_n)
      s_lone_write |=> page_rx == $past(page_rx) && int_pending == $past(int_pending)
        && remote_fault == $past(remote_fault) && rd_data == SUMMARY_RESET;
  endproperty
  a_write: assert property (p_write) else $error("write changed state");

endmodule // phy_status_summary_low

// ===== verif/mgmt_reader.sv
// Purpose: management reader model on the far side
// Assumes: read called at a falling edge of clk_sys
// Notes: released address shows its inverse
`timescale 1ns/1ps
module mgmt_reader (
  input wire logic clk_sys,
  output logic rd_strobe,
  output logic [4:0] reg_addr
);
  initial begin
    rd_strobe = 1'b0;
    reg_addr = 5'h00;
  end
  // duplex and speed trusted only with link up
  function automatic logic modes_valid(input logic [15:0] d);
    return d[0];
  endfunction
  task automatic read(input logic [4:0] a);
    rd_strobe = 1'b1;
    reg_addr = a;
    @(negedge clk_sys);
    rd_strobe = 1'b0;
    reg_addr = ~a;
  endtask
endmodule // mgmt_reader

// ===== verif/tb_phy_status_summary_low.sv
// Purpose: random checks of the low status summary bits
// Assumes: inputs change at the falling edge
// Notes: sticky flags are given three cycles to settle
`timescale 1ns/1ps
module tb_phy_status_summary_low;
  import phy_status_summary_pkg::*;
  // ****************
  // stimulus and model
  // ****************
  logic clk_sys = 1'b0, arst_n = 1'b0, wr_strobe = 1'b0, rd_strobe;
  logic [4:0] reg_addr;
  logic [5:0] lv = 6'h00;
  logic [2:0] ev = 3'h0;
  logic [15:0] rd_data;
  logic [STATUS_BITS-1:0] status_bits;
  logic [31:0] seed = 32'h00000022;
  logic [8:0] exp_b;
  logic [1:0] k;
  bit pr, ip, rf;
  int n_mismatch = 0, checked = 0, cyc = 0;
  logic [4:0] tab [4] = '{ADDR_AUTONEG_EXPANSION, ADDR_INTERRUPT_STATUS, ADDR_BASIC_STATUS, ADDR_STATUS_SUMMARY};
  phy_status_summary_low dut (.clk_sys(clk_sys), .arst_n(arst_n), .rd_strobe(rd_strobe), .wr_strobe(wr_strobe),
    .reg_addr(reg_addr), .page_rx_event(ev[2]), .interrupt_event(ev[1]), .remote_fault_event(ev[0]),
    .jabber_flag(lv[5]), .autoneg_done(lv[4]), .loopback_en(lv[3]), .full_duplex(lv[2]), .speed_10(lv[1]),
    .link_flag(lv[0]), .rd_data(rd_data), .status_bits(status_bits));
  mgmt_reader mgr (.clk_sys(clk_sys), .rd_strobe(rd_strobe), .reg_addr(reg_addr));
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic side_read(input logic [1:0] j);
    mgr.read(tab[j]);
    pr &= (j != 2'h0);
    ip &= (j != 2'h1);
    rf &= (j != 2'h2);
    chk(rd_data, 16'h0000);
  endtask
  task automatic results();
    if (n_mismatch == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial forever #2.5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      results();
    end
  end
  initial begin
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys);
    arst_n = 1'b1;
    chk({7'h00, status_bits}, 16'h0000);
    for (int i = 0; i < 300; i++) begin
      if (i == 150) begin
        arst_n = 1'b0;
        pr = 1'b0;
        ip = 1'b0;
        rf = 1'b0;
        repeat (2) @(negedge clk_sys);
        chk({7'h00, status_bits}, 16'h0000);
        chk(rd_data, 16'h0000);
        arst_n = 1'b1;
      end
      seed = xs(seed);
      lv = seed[5:0];
      ev = seed[8:6];
      wr_strobe = seed[9];
      k = seed[12:11];
      // same-cycle event and clearing read: set wins
      if (seed[13] && seed[10] && k != 2'h3) side_read(k);
      else @(negedge clk_sys);
      pr |= ev[2];
      ip |= ev[1];
      rf |= ev[0];
      ev = 3'h0;
      wr_strobe = 1'b0;
      if (!seed[13] && seed[10] && k != 2'h3) side_read(k);
      repeat (3) @(negedge clk_sys);
      exp_b = {pr, ip, rf, lv};
      chk({7'h00, status_bits}, {7'h00, exp_b});
      mgr.read(ADDR_STATUS_SUMMARY);
      chk(rd_data, {7'h00, exp_b});
      if (mgr.modes_valid(rd_data)) chk({14'h0000, rd_data[2:1]}, {14'h0000, lv[2:1]});
      @(negedge clk_sys);
      chk(rd_data, 16'h0000);
    end
    results();
  end
endmodule // tb_phy_status_summary_low
